/* File: rx_line_input_cfg.svh */
// Purpose: Timing counts and reset values for the receive line input selection.
// Assumes: Core clock of 200 MHz; line rates of 2048 kbit/s and 1544 kbit/s.
// Notes:   Counts are derived from the rates, rounded down to whole cycles.
`ifndef RX_LINE_INPUT_CFG_SVH
`define RX_LINE_INPUT_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and line rates
// ----------------------------------------------------------------------------
`define RXSEL_CLK_KHZ       200000
`define RXSEL_E1_KBPS       2048
`define RXSEL_T1_KBPS       1544
`define RXSEL_E1_BIT_CYC    (`RXSEL_CLK_KHZ / `RXSEL_E1_KBPS)
`define RXSEL_T1_BIT_CYC    (`RXSEL_CLK_KHZ / `RXSEL_T1_KBPS)

// ----------------------------------------------------------------------------
// Widths, depths and reset values
// ----------------------------------------------------------------------------
`define RXSEL_PHASE_W       8
`define RXSEL_SYNC_STAGES   2
`define RXSEL_FIFO_DEPTH    4
`define RXSEL_PHASE_RST     8'h00

`endif

/* File: rx_line_input_pkg.sv */
// Purpose: Types shared by the receive line input selection and its FIFO.
// Assumes: Constants come from rx_line_input_cfg.svh.
// Notes:   Mode codes are binary and fixed.
package rx_line_input_pkg;

    // ------------------------------------------------------------------------
    // Receive input modes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ANALOG = 2'b00,
        MODE_DUAL   = 2'b01,
        MODE_NRZ    = 2'b10,
        MODE_CMI    = 2'b11
    } rx_mode_e;

    // ------------------------------------------------------------------------
    // One received symbol: both rails, or the data bit on pos_bit alone
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic pos_bit;
        logic neg_bit;
    } rx_symbol_s;

    typedef logic [7:0] phase_t;

endpackage : rx_line_input_pkg

/* File: rx_symbol_fifo.sv */
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; DEPTH is a power of two.
// Notes:   Full and empty come from a pointer pair with one extra wrap bit.
`timescale 1ns/10ps
module rx_symbol_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             full;
    logic             empty;

    assign empty     = (wr_ptr_r == rd_ptr_r);
    assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (in_valid && !full) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
        end else if (in_valid && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_ptr_r <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

endmodule : rx_symbol_fifo

/* File: rx_line_input_select.sv */
// Purpose: Receive input selection, polarity and clock recovery for one line port.
// Assumes: Configuration inputs come from logic on clk_sys; pins are asynchronous.
// Notes:   Instantiate once per line port; analog inputs arrive as sliced levels.
//
// Overview of operation
// - Mode select cleared: data comes from the two analog line inputs.
// - Mode select and upper code bit set: dual-rail input on both rail pins.
// - Dual-rail clock is recovered by a DPLL that latches both rails.
// - Mode select set, upper code bit cleared: single-rail data from optical pin.
// - Single-rail non-CMI data is sampled on each falling external clock edge.
// - Polarity select inverts or passes rail and optical inputs; value zero means active low.
// - Code field 01 selects CMI: DPLL recovers clock and data, no external clock.
// - External clock is used only with mode select set and code field 00.
// - External clock activity is ignored while CMI coding is selected.
`timescale 1ns/10ps
`include "rx_line_input_cfg.svh"
module rx_line_input_select (
    input  wire logic                          clk_sys,
    input  wire logic                          resetn,
    input  wire logic                          digital_line_mode_select,
    input  wire logic [1:0]                    rx_code_select_field,
    input  wire logic                          rx_input_polarity_select,
    input  wire logic                          line_rate_t1,
    input  wire logic                          rx_analog_line_in_a,
    input  wire logic                          rx_analog_line_in_b,
    input  wire logic                          rx_positive_rail_in,
    input  wire logic                          rx_negative_rail_in,
    input  wire logic                          rx_optical_data_in,
    input  wire logic                          rx_external_clock_in,
    output rx_line_input_pkg::rx_symbol_s      rx_symbol_r,
    output logic                               rx_valid_r,
    input  wire logic                          rx_ready,
    output rx_line_input_pkg::rx_mode_e        rx_mode_r,
    output logic                               rx_overrun_r
);
    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    localparam int NPIN = 6;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1_r;
    logic [NPIN-1:0] pin_s2_r;

    assign pin_raw = {rx_external_clock_in, rx_optical_data_in, rx_negative_rail_in,
                      rx_positive_rail_in, rx_analog_line_in_b, rx_analog_line_in_a};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    pin_s1_r[gi] <= 1'b0;
                    pin_s2_r[gi] <= 1'b0;
                end else begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Mode decode and polarity
    // ------------------------------------------------------------------------
    rx_line_input_pkg::rx_mode_e mode;
    logic                        pol_inv;
    logic                        sel_a;
    logic                        sel_b;
    logic                        sel_opt;

    always_comb begin
        if (!digital_line_mode_select) begin
            mode = rx_line_input_pkg::MODE_ANALOG;
        end else if (rx_code_select_field[1]) begin
            mode = rx_line_input_pkg::MODE_DUAL;
        end else if (rx_code_select_field[0]) begin
            mode = rx_line_input_pkg::MODE_CMI;
        end else begin
            mode = rx_line_input_pkg::MODE_NRZ;
        end
    end

    // Polarity select low means the digital pins are active low, so they are inverted.
    assign pol_inv = !rx_input_polarity_select;

    // Only the pins of the selected mode reach the recovery logic.
    always_comb begin
        sel_a   = 1'b0;
        sel_b   = 1'b0;
        sel_opt = 1'b0;
        case (mode)
            rx_line_input_pkg::MODE_ANALOG: begin
                sel_a = pin_s2_r[0];
                sel_b = pin_s2_r[1];
            end
            rx_line_input_pkg::MODE_DUAL: begin
                sel_a = pin_s2_r[2] ^ pol_inv;
                sel_b = pin_s2_r[3] ^ pol_inv;
            end
            rx_line_input_pkg::MODE_NRZ,
            rx_line_input_pkg::MODE_CMI: begin
                sel_opt = pin_s2_r[4] ^ pol_inv;
            end
            default: begin
                sel_opt = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Edge history and mode tracking
    // ------------------------------------------------------------------------
    logic                        pulse_prev_r;
    logic                        opt_prev_r;
    logic                        xclk_prev_r;
    logic                        xclk_fall;
    logic                        pulse_rise;
    logic                        opt_fall;
    logic                        mode_change;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pulse_prev_r <= 1'b0;
            opt_prev_r   <= 1'b0;
            xclk_prev_r  <= 1'b0;
        end else begin
            pulse_prev_r <= sel_a | sel_b;
            opt_prev_r   <= sel_opt;
            xclk_prev_r  <= pin_s2_r[5];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_mode_r <= rx_line_input_pkg::MODE_ANALOG;
        end else begin
            rx_mode_r <= mode;
        end
    end

    assign pulse_rise  = (sel_a | sel_b) && !pulse_prev_r;
    assign opt_fall    = opt_prev_r && !sel_opt;
    assign mode_change = (mode != rx_mode_r);
    // The external clock is looked at in single-rail NRZ mode only.
    assign xclk_fall   = (mode == rx_line_input_pkg::MODE_NRZ) && xclk_prev_r
                         && !pin_s2_r[5];

    // ------------------------------------------------------------------------
    // Digital PLL: a bit-period phase counter pulled in by line edges
    // ------------------------------------------------------------------------
    logic [`RXSEL_PHASE_W-1:0] period;
    logic [`RXSEL_PHASE_W-1:0] quarter;
    logic [`RXSEL_PHASE_W-1:0] three_q;
    logic [`RXSEL_PHASE_W-1:0] phase_r;
    logic                      resync;

    assign period  = line_rate_t1 ? `RXSEL_PHASE_W'(`RXSEL_T1_BIT_CYC)
                                  : `RXSEL_PHASE_W'(`RXSEL_E1_BIT_CYC);
    assign quarter = period >> 2;
    assign three_q = period - quarter;

    // Dual-rail pulses start at the bit boundary. A CMI zero always rises mid-bit,
    // so only a falling optical edge marks a boundary; rising edges would let the
    // phase lock half a bit off.
    always_comb begin
        case (mode)
            rx_line_input_pkg::MODE_ANALOG,
            rx_line_input_pkg::MODE_DUAL: begin
                resync = pulse_rise;
            end
            rx_line_input_pkg::MODE_CMI: begin
                resync = opt_fall;
            end
            default: begin
                resync = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase_r <= `RXSEL_PHASE_RST;
        end else if (mode_change || resync || (phase_r >= period - 1'b1)) begin
            phase_r <= `RXSEL_PHASE_RST;
        end else begin
            phase_r <= phase_r + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Symbol capture per mode
    // ------------------------------------------------------------------------
    logic                           cmi_half_r;
    logic                           cap_valid;
    rx_line_input_pkg::rx_symbol_s  cap_sym;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmi_half_r <= 1'b0;
        end else if (mode == rx_line_input_pkg::MODE_CMI && phase_r == quarter) begin
            cmi_half_r <= sel_opt;
        end
    end

    // CMI: equal halves carry a one, a 0-to-1 pair carries a zero.
    always_comb begin
        cap_valid       = 1'b0;
        cap_sym.pos_bit = 1'b0;
        cap_sym.neg_bit = 1'b0;
        case (mode)
            rx_line_input_pkg::MODE_ANALOG,
            rx_line_input_pkg::MODE_DUAL: begin
                cap_valid       = !mode_change && (phase_r == quarter);
                cap_sym.pos_bit = sel_a;
                cap_sym.neg_bit = sel_b;
            end
            rx_line_input_pkg::MODE_NRZ: begin
                cap_valid       = !mode_change && xclk_fall;
                cap_sym.pos_bit = sel_opt;
            end
            rx_line_input_pkg::MODE_CMI: begin
                cap_valid       = !mode_change && (phase_r == three_q);
                cap_sym.pos_bit = (cmi_half_r == sel_opt);
            end
            default: begin
                cap_valid = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Hold stage: the line cannot be stalled, so a full FIFO shows as overrun
    // ------------------------------------------------------------------------
    logic                           hold_valid_r;
    rx_line_input_pkg::rx_symbol_s  hold_sym_r;
    logic                           fifo_in_ready;
    logic                           fifo_out_valid;
    logic                           fifo_out_ready;
    rx_line_input_pkg::rx_symbol_s  fifo_out_data;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hold_valid_r <= 1'b0;
            hold_sym_r   <= '0;
        end else if (cap_valid) begin
            hold_valid_r <= 1'b1;
            hold_sym_r   <= cap_sym;
        end else if (fifo_in_ready) begin
            hold_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_overrun_r <= 1'b0;
        end else if (cap_valid && hold_valid_r && !fifo_in_ready) begin
            rx_overrun_r <= 1'b1;
        end
    end

    rx_symbol_fifo #(
        .WIDTH ($bits(rx_line_input_pkg::rx_symbol_s)),
        .DEPTH (`RXSEL_FIFO_DEPTH)
    ) i_rx_symbol_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (hold_valid_r),
        .in_ready  (fifo_in_ready),
        .in_data   (hold_sym_r),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------------------
    // Registered output stage
    // ------------------------------------------------------------------------
    assign fifo_out_ready = !rx_valid_r || rx_ready;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_valid_r  <= 1'b0;
            rx_symbol_r <= '0;
        end else if (fifo_out_ready) begin
            rx_valid_r  <= fifo_out_valid;
            rx_symbol_r <= fifo_out_data;
        end
    end

endmodule : rx_line_input_select

/* File: rx_line_input_monitor.sv */
// Purpose: Port checker for the receive line input selection.
// Assumes: One clock domain; E1 bit period of the configuration header.
// Notes:   Attached by bind at the foot of this file.
`timescale 1ns/10ps
module rx_line_input_monitor (
    input wire logic                          clk_sys,
    input wire logic                          resetn,
    input wire logic                          digital_line_mode_select,
    input wire logic [1:0]                    rx_code_select_field,
    input wire logic                          rx_ready,
    input wire rx_line_input_pkg::rx_symbol_s rx_symbol_r,
    input wire logic                          rx_valid_r,
    input wire rx_line_input_pkg::rx_mode_e   rx_mode_r,
    input wire logic                          rx_overrun_r
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    logic       up_r;
    logic [7:0] gap_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) up_r <= 1'b0;
        else up_r <= 1'b1;
    end
    // Recovered modes emit a symbol each period, so a long silence means a dead DPLL.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) gap_r <= 8'h00;
        else if (rx_valid_r || rx_mode_r == rx_line_input_pkg::MODE_NRZ) gap_r <= 8'h00;
        else gap_r <= gap_r + 8'h01;
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_analog;
        up_r && !$past(digital_line_mode_select) |-> rx_mode_r == rx_line_input_pkg::MODE_ANALOG;
    endproperty
    a_analog: assert property (p_analog) else $error("analog mode not selected");
    property p_dual;
        up_r && $past(digital_line_mode_select) && $past(rx_code_select_field) >= 2'h2
            |-> rx_mode_r == rx_line_input_pkg::MODE_DUAL;
    endproperty
    a_dual: assert property (p_dual) else $error("dual rail mode not selected");
    property p_nrz;
        up_r && $past(digital_line_mode_select) && $past(rx_code_select_field) == 2'h0
            |-> rx_mode_r == rx_line_input_pkg::MODE_NRZ;
    endproperty
    a_nrz: assert property (p_nrz) else $error("single rail mode not selected");
    property p_cmi;
        up_r && $past(digital_line_mode_select) && $past(rx_code_select_field) == 2'h1
            |-> rx_mode_r == rx_line_input_pkg::MODE_CMI;
    endproperty
    a_cmi: assert property (p_cmi) else $error("coded mode not selected");
    property p_quiet;
        !up_r |-> !rx_valid_r && !rx_overrun_r && rx_mode_r == rx_line_input_pkg::MODE_ANALOG;
    endproperty
    a_quiet: assert property (p_quiet) else $error("output active after reset");
    property p_hold;
        rx_valid_r && !rx_ready |=> rx_valid_r && $stable(rx_symbol_r);
    endproperty
    a_hold: assert property (p_hold) else $error("symbol dropped while stalled");
    property p_rate;
        gap_r < 8'hc8;
    endproperty
    a_rate: assert property (p_rate) else $error("no recovered symbol in time");
    property p_sticky;
        rx_overrun_r |=> rx_overrun_r;
    endproperty
    a_sticky: assert property (p_sticky) else $error("overrun flag lost");
endmodule : rx_line_input_monitor

bind rx_line_input_select rx_line_input_monitor i_rx_line_input_monitor (
    .clk_sys                  (clk_sys),
    .resetn                   (resetn),
    .digital_line_mode_select (digital_line_mode_select),
    .rx_code_select_field     (rx_code_select_field),
    .rx_ready                 (rx_ready),
    .rx_symbol_r              (rx_symbol_r),
    .rx_valid_r               (rx_valid_r),
    .rx_mode_r                (rx_mode_r),
    .rx_overrun_r             (rx_overrun_r)
);

/* File: rx_line_source.sv */
// Purpose: Far end line and optical source driving the receive pins.
// Assumes: E1 rates; the bench calls send while the block is in the matching mode.
// Notes:   Unselected pins carry a toggling pattern so stale levels cannot pass.
`timescale 1ns/10ps
`include "rx_line_input_cfg.svh"
module rx_line_source (
    input  wire logic active_high,
    output logic      rx_analog_line_in_a,
    output logic      rx_analog_line_in_b,
    output logic      rx_positive_rail_in,
    output logic      rx_negative_rail_in,
    output logic      rx_optical_data_in,
    output logic      rx_external_clock_in
);
    // ----------------------------------------------------------------
    // Line drive
    // ----------------------------------------------------------------
    localparam int HALF_NS = (`RXSEL_E1_BIT_CYC) * 5 / 2;
    logic nz;
    logic inv;
    logic lvl;
    initial begin
        {rx_analog_line_in_a, rx_analog_line_in_b, rx_positive_rail_in} = 3'h0;
        {rx_negative_rail_in, rx_optical_data_in, rx_external_clock_in} = 3'h0;
        nz = 1'b0;
    end
    task automatic drive(input int kind, input logic a, input logic b);
        nz = ~nz;
        rx_optical_data_in  = (kind < 2) ? a ^ inv : nz;
        rx_positive_rail_in = (kind == 2) ? a ^ inv : nz;
        rx_negative_rail_in = (kind == 2) ? b ^ inv : ~nz;
        rx_analog_line_in_a = (kind == 3) ? a : nz;
        rx_analog_line_in_b = (kind == 3) ? b : ~nz;
        if (kind != 0) rx_external_clock_in = nz;
    endtask : drive
    // Kind 0 single rail, 1 coded, 2 dual rail, 3 analog; bits go out msb first.
    task automatic send(input int kind, input logic [15:0] d);
        inv = ~active_high;
        lvl = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (kind == 0) begin
                drive(0, d[i], 1'b0);
                #20 rx_external_clock_in = 1'b1;
                #40 rx_external_clock_in = 1'b0;
                #20;
            end else begin
                if (d[i]) lvl = ~lvl;
                if (kind == 1) drive(1, d[i] ? lvl : 1'b0, 1'b0);
                else drive(kind, d[i] & lvl, d[i] & ~lvl);
                #(HALF_NS);
                if (kind == 1) drive(1, d[i] ? lvl : 1'b1, 1'b0);
                else drive(kind, 1'b0, 1'b0);
                #(HALF_NS);
            end
        end
        rx_optical_data_in = ~rx_optical_data_in;
        {rx_positive_rail_in, rx_negative_rail_in} = {inv, inv};
        {rx_analog_line_in_a, rx_analog_line_in_b, rx_external_clock_in} = 3'h0;
    endtask : send
endmodule : rx_line_source

/* File: tb_rx_line_input_select.sv */
// Purpose: Self-checking bench for the receive line input selection.
// Assumes: E1 rate except in t_rate, which runs at T1; the far end model drives every line pin.
// Notes:   Symbols are collected with ready high and judged per scenario.
`timescale 1ns/10ps
module tb_rx_line_input_select;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam logic [15:0] D = 16'h00b6;
    logic clk_sys, resetn, dl, pol, ready, a_a, a_b, r_p, r_n, o_d, e_c, vld, ovr, t1;
    logic [1:0] fld;
    rx_line_input_pkg::rx_symbol_s sym;
    rx_line_input_pkg::rx_mode_e   mode;
    rx_line_input_pkg::rx_symbol_s q[$];
    int fail_count = 0;
    int total_checks = 0;
    rx_line_input_select i_rx_line_input_select (.clk_sys(clk_sys), .resetn(resetn),
        .digital_line_mode_select(dl), .rx_code_select_field(fld),
        .rx_input_polarity_select(pol), .line_rate_t1(t1), .rx_analog_line_in_a(a_a),
        .rx_analog_line_in_b(a_b), .rx_positive_rail_in(r_p), .rx_negative_rail_in(r_n),
        .rx_optical_data_in(o_d), .rx_external_clock_in(e_c), .rx_symbol_r(sym),
        .rx_valid_r(vld), .rx_ready(ready), .rx_mode_r(mode), .rx_overrun_r(ovr));
    rx_line_source i_rx_line_source (.active_high(pol), .rx_analog_line_in_a(a_a),
        .rx_analog_line_in_b(a_b), .rx_positive_rail_in(r_p), .rx_negative_rail_in(r_n),
        .rx_optical_data_in(o_d), .rx_external_clock_in(e_c));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic collect(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            if (vld === 1'b1 && ready === 1'b1) q.push_back(sym);
        end
    endtask : collect
    // Stale symbols of the previous mode are drained before a scenario starts.
    task automatic set_cfg(input logic d, input logic [1:0] f, input logic p);
        @(posedge clk_sys);
        dl <= d;
        fld <= f;
        pol <= p;
        collect(60);
        q.delete();
    endtask : set_cfg
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_modes;
        rx_line_input_pkg::rx_mode_e m;
        for (int i = 0; i < 8; i++) begin
            set_cfg(i[2], i[1:0], 1'b1);
            m = !i[2] ? rx_line_input_pkg::MODE_ANALOG : i[1] ? rx_line_input_pkg::MODE_DUAL
                : i[0] ? rx_line_input_pkg::MODE_CMI : rx_line_input_pkg::MODE_NRZ;
            check({14'h0, mode}, {14'h0, m});
        end
    endtask : t_modes
    task automatic t_nrz(input logic p);
        set_cfg(1'b1, 2'h0, p);
        fork
            i_rx_line_source.send(0, D);
            collect(320);
        join
        check(16'(q.size()), 16'h0010);
        foreach (q[k]) check({14'h0, q[k]}, {14'h0, D[15-k], 1'b0});
    endtask : t_nrz
    task automatic t_cmi;
        logic [7:0] w;
        logic       hit;
        w = 8'h00;
        hit = 1'b0;
        set_cfg(1'b1, 2'h1, 1'b1);
        fork
            i_rx_line_source.send(1, D);
            collect(1752);
        join
        foreach (q[k]) begin
            w = {w[6:0], q[k].pos_bit};
            if (w === D[7:0]) hit = 1'b1;
        end
        check({15'h0, hit}, 16'h0001);
    endtask : t_cmi
    task automatic t_rails(input logic analog);
        int         n;
        logic [4:0] seq;
        n = 0;
        seq = 5'h00;
        set_cfg(~analog, 2'h2, 1'b1);
        fork
            i_rx_line_source.send(analog ? 3 : 2, D);
            collect(1752);
        join
        foreach (q[k]) if (q[k] !== 2'h0) begin
            seq = {seq[3:0], q[k].pos_bit};
            n++;
        end
        check(16'(n), 16'h0005);
        check({11'h0, seq}, 16'h0015);
    endtask : t_rails
    // A quiet dual-rail line free-runs, so eight T1 bit periods give eight symbols.
    task automatic t_rate;
        t1 <= 1'b1;
        set_cfg(1'b1, 2'h2, 1'b1);
        collect(1032);
        check(16'(q.size()), 16'h0008);
        t1 <= 1'b0;
    endtask : t_rate
    // Overrun is sticky, so this runs last.
    task automatic t_overrun;
        set_cfg(1'b1, 2'h2, 1'b1);
        ready <= 1'b0;
        repeat (1000) @(posedge clk_sys);
        check({14'h0, vld, ovr}, 16'h0003);
    endtask : t_overrun
    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        {resetn, dl, pol, fld, t1} = 6'h08;
        ready = 1'b1;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_modes();
        t_nrz(1'b1);
        t_nrz(1'b0);
        t_cmi();
        t_rails(1'b0);
        t_rails(1'b1);
        t_rate();
        t_overrun();
        conclude();
    end
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
endmodule : tb_rx_line_input_select
